// ==== logic/spp_pkg.sv ====
// Constants for the serial program port of the controller.
// Assumes a 200 MHz system clock sampling the programmer's pins.
package spp_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam logic [31:0] ENTRY_KEY = 32'h4d434851;
    localparam int KEY_BITS = 32;
    localparam int CMD_BITS = 4;
    localparam int FIRST_CMD_BITS = 9;
    localparam int INSTR_BITS = 24;
    localparam int EXEC_CLOCKS = 4;
    localparam int VISI_BITS = 16;
    localparam int MEM_CTRL_WR_BIT = 15;
    localparam logic [3:0] CMD_EXEC = 4'h0;
    localparam logic [3:0] CMD_READOUT = 4'h1;
    localparam logic [23:0] NOP_WORD = 24'h000000;
    localparam logic [23:0] PC_RESET = 24'h000000;
    localparam logic [23:0] PC_SAFE_BASE = 24'h000200;
    localparam logic [23:0] PC_STEP = 24'h000002;
    localparam logic [23:0] PC_LIMIT_DEF = 24'h008000;
    // Settling wait after master_clear rises behind a good key
    localparam int ENTRY_SETTLE_NS = 1000;
    localparam int SETTLE_CYCLES = (ENTRY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_WIDTH = 24;
    localparam int FIFO_DEPTH = 4;
endpackage

// ==== logic/spp_port.sv ====
// Serial program port: key entry, command decode, instruction feed, readout.
// Assumes the pins come from another clock domain and a CPU drains the FIFO.
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Instruction FIFO
// ****************************************
module spp_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = i_valid && o_ready;
    wire pop = o_valid && i_ready;
    assign o_ready = cnt_reg != (AW+1)'(DEPTH);
    assign o_valid = cnt_reg != '0;
    assign o_data = mem[rd_reg];
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_reg] <= i_data;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            if (pop) rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module spp_port #(
    parameter logic [23:0] PC_LIMIT = spp_pkg::PC_LIMIT_DEF
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_prog_clock,
    input wire logic i_prog_data,
    output logic o_prog_data,
    output logic o_prog_data_oe,
    input wire logic i_master_clear,
    output logic o_prog_mode,
    output logic o_io_hiz,
    output logic o_cpu_suspend,
    output logic o_cpu_exec,
    output logic [23:0] o_instr_data,
    output logic o_instr_valid,
    input wire logic i_instr_ready,
    output logic o_instr_lost,
    input wire logic [15:0] i_visi,
    input wire logic i_pc_load,
    input wire logic [23:0] i_pc_value,
    output logic [23:0] o_pc,
    output logic o_dev_reset
);
    typedef enum logic [2:0] {ST_OFF, ST_SETTLE, ST_FIRST, ST_CMD, ST_INSTR, ST_READ} spp_state_e;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] ck_sync_reg;
    logic [2:0] dt_sync_reg;
    logic [2:0] mc_sync_reg;
    logic ck_lvl_reg;
    logic mc_lvl_reg;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ck_sync_reg <= '0;
            dt_sync_reg <= '0;
            mc_sync_reg <= '0;
            ck_lvl_reg <= 1'b0;
            mc_lvl_reg <= 1'b0;
        end else begin
            ck_sync_reg <= {ck_sync_reg[1:0], i_prog_clock};
            dt_sync_reg <= {dt_sync_reg[1:0], i_prog_data};
            mc_sync_reg <= {mc_sync_reg[1:0], i_master_clear};
            if (ck_sync_reg[1] == ck_sync_reg[2]) ck_lvl_reg <= ck_sync_reg[2];
            if (mc_sync_reg[1] == mc_sync_reg[2]) mc_lvl_reg <= mc_sync_reg[2];
        end
    end
    wire ck_agree = ck_sync_reg[1] == ck_sync_reg[2];
    wire ck_rise = ck_agree && ck_sync_reg[2] && !ck_lvl_reg;
    wire ck_fall = ck_agree && !ck_sync_reg[2] && ck_lvl_reg;
    wire mc_agree = mc_sync_reg[1] == mc_sync_reg[2];
    wire mc_rise = mc_agree && mc_sync_reg[2] && !mc_lvl_reg;
    wire mc_fall = mc_agree && !mc_sync_reg[2] && mc_lvl_reg;
    wire dbit = dt_sync_reg[2];

    // ****************************************
    // Sequencer
    // ****************************************
    spp_state_e state_reg;
    spp_state_e state_next;
    logic [31:0] key_reg;
    logic [23:0] shift_reg;
    logic [15:0] visi_reg;
    logic [5:0] bit_reg;
    logic [15:0] settle_reg;
    logic [2:0] exec_reg;
    logic out_reg;
    logic oe_reg;
    logic lost_reg;
    logic [23:0] pc_reg;
    logic pc_armed_reg;
    logic reset_reg;
    logic push;
    logic [23:0] push_word;
    logic fifo_ready;

    wire key_ok = key_reg == spp_pkg::ENTRY_KEY;
    wire [3:0] cmd_word = {shift_reg[2:0], dbit};
    wire last_bit = ck_fall && (bit_reg == 6'd1);
    wire settle_done = settle_reg == 16'(spp_pkg::SETTLE_CYCLES);
    wire [23:0] pc_inc = pc_reg + spp_pkg::PC_STEP;
    wire pc_bad = (pc_inc < spp_pkg::PC_SAFE_BASE) || (pc_inc >= PC_LIMIT);
    wire pc_trip = push && !i_pc_load && pc_armed_reg && pc_bad;
    wire in_mode = state_reg != ST_OFF;
    // Words go straight to the FIFO; the forced first command pushes NOP_WORD instead of its bits
    wire push_state = state_reg == ST_FIRST || state_reg == ST_INSTR;
    assign push = last_bit && !mc_fall && push_state;
    assign push_word = (state_reg == ST_FIRST) ? spp_pkg::NOP_WORD
        : {shift_reg[22:0], dbit};

    always_comb begin
        state_next = state_reg;
        if (mc_fall || pc_trip) begin
            state_next = ST_OFF;
        end else begin
            unique case (state_reg)
                ST_OFF: if (mc_rise && key_ok) state_next = ST_SETTLE;
                ST_SETTLE: if (settle_done) state_next = ST_FIRST;
                ST_FIRST: if (last_bit) state_next = ST_INSTR;
                ST_CMD: if (last_bit) begin
                    if (cmd_word == spp_pkg::CMD_EXEC) state_next = ST_INSTR;
                    else if (cmd_word == spp_pkg::CMD_READOUT) state_next = ST_READ;
                    else state_next = ST_CMD;
                end
                ST_INSTR: if (last_bit) state_next = ST_CMD;
                ST_READ: if (last_bit) state_next = ST_CMD;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_reg <= ST_OFF;
            key_reg <= '0;
            shift_reg <= '0;
            bit_reg <= '0;
            settle_reg <= '0;
        end else begin
            state_reg <= state_next;
            // A stale key must not re-enter the mode on the next entry pulse
            if (state_reg != ST_OFF || mc_fall) key_reg <= '0;
            else if (ck_fall) key_reg <= {key_reg[30:0], dbit};
            if (state_reg == ST_SETTLE) settle_reg <= settle_reg + 16'h0001;
            else settle_reg <= '0;
            if (ck_fall && state_reg != ST_OFF && state_reg != ST_SETTLE) begin
                shift_reg <= {shift_reg[22:0], dbit};
                bit_reg <= bit_reg - 6'h01;
            end
            if (state_next != state_reg) begin
                unique case (state_next)
                    ST_FIRST: bit_reg <= 6'(spp_pkg::FIRST_CMD_BITS);
                    ST_INSTR: bit_reg <= 6'(spp_pkg::INSTR_BITS);
                    ST_READ: bit_reg <= 6'(spp_pkg::VISI_BITS);
                    default: bit_reg <= 6'(spp_pkg::CMD_BITS);
                endcase
            end else if (state_reg == ST_CMD && last_bit) begin
                bit_reg <= 6'(spp_pkg::CMD_BITS);
            end
        end
    end

    // ****************************************
    // Execute window, readout driver, program counter
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            exec_reg <= '0;
            visi_reg <= '0;
            out_reg <= 1'b0;
            oe_reg <= 1'b0;
            lost_reg <= 1'b0;
            pc_reg <= spp_pkg::PC_RESET;
            pc_armed_reg <= 1'b0;
            reset_reg <= 1'b0;
        end else begin
            reset_reg <= pc_trip;
            if (push && !fifo_ready) lost_reg <= 1'b1;
            else if (state_reg == ST_OFF) lost_reg <= 1'b0;
            if (push && !pc_trip) exec_reg <= 3'(spp_pkg::EXEC_CLOCKS);
            else if (ck_fall && exec_reg != '0) exec_reg <= exec_reg - 3'h1;
            // Bit 15 carries the memory control write bit when polled
            if (state_next == ST_READ && state_reg != ST_READ) begin
                visi_reg <= {i_visi[14:0], 1'b0};
                out_reg <= i_visi[spp_pkg::MEM_CTRL_WR_BIT];
                oe_reg <= 1'b1;
            end else if (state_reg == ST_READ && state_next == ST_READ) begin
                if (ck_rise && bit_reg != 6'(spp_pkg::VISI_BITS)) begin
                    out_reg <= visi_reg[15];
                    visi_reg <= {visi_reg[14:0], 1'b0};
                end
            end else begin
                oe_reg <= 1'b0;
                out_reg <= 1'b0;
            end
            if (i_pc_load) begin
                pc_reg <= i_pc_value;
                pc_armed_reg <= i_pc_value >= spp_pkg::PC_SAFE_BASE;
            end else if (push) begin
                pc_reg <= pc_inc;
            end
            if (state_reg == ST_OFF) pc_armed_reg <= 1'b0;
        end
    end

    spp_fifo #(
        .WIDTH(spp_pkg::FIFO_WIDTH),
        .DEPTH(spp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_data(push_word),
        .i_valid(push),
        .o_ready(fifo_ready),
        .o_data(o_instr_data),
        .o_valid(o_instr_valid),
        .i_ready(i_instr_ready)
    );

    assign o_prog_data = out_reg;
    assign o_prog_data_oe = oe_reg;
    assign o_prog_mode = in_mode;
    assign o_io_hiz = in_mode;
    assign o_cpu_suspend = state_reg == ST_INSTR;
    assign o_cpu_exec = exec_reg != '0;
    assign o_instr_lost = lost_reg;
    assign o_pc = pc_reg;
    assign o_dev_reset = reset_reg;

    // ****************************************
    // Checks
    // ****************************************
    AST_KEY_GATE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        state_reg == ST_OFF && state_next == ST_SETTLE |-> key_ok) else $error("entry without key");
    AST_SETTLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(state_reg == ST_SETTLE) |-> state_reg == ST_SETTLE [*8]) else $error("settle short");
    AST_FIRST_NOP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        state_reg == ST_FIRST && push |-> push_word == spp_pkg::NOP_WORD) else $error("no nop");
    AST_FIRST_LEN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(state_reg == ST_FIRST) |-> bit_reg == 6'd9) else $error("first length");
    AST_SUSPEND: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(o_cpu_suspend) |-> bit_reg == 6'd24) else $error("suspend length");
    AST_EXEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        state_reg == ST_INSTR && push && !pc_trip |=> exec_reg == 3'd4 && state_reg == ST_CMD)
        else $error("exec window");
    AST_HIZ: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        state_reg == ST_CMD |-> o_io_hiz) else $error("pins not released");
    AST_EXIT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        mc_fall |=> state_reg == ST_OFF) else $error("no exit");
    AST_OE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_prog_data_oe |-> $past(state_next) == ST_READ) else $error("drive outside readout");
    AST_PC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        pc_trip |=> o_dev_reset && state_reg == ST_OFF) else $error("pc trip lost");
    CV_ENTRY: cover property (@(posedge i_sys_clk) state_reg == ST_SETTLE ##[1:300] state_reg == ST_FIRST);
    CV_EXEC: cover property (@(posedge i_sys_clk) state_reg == ST_INSTR && push);
    CV_READ: cover property (@(posedge i_sys_clk) state_reg == ST_READ && last_bit);
    CV_TRIP: cover property (@(posedge i_sys_clk) pc_trip);
endmodule

`default_nettype wire

// ==== verification/spp_prog_model.sv ====
// Programmer model: drives the port's clock, data and master_clear pins.
// Assumes the bench resolves the data wire from the port's output enable alone.
`timescale 1ns/100ps
`default_nettype none

module spp_prog_model (
    output logic o_prog_clock,
    output logic o_prog_data,
    output logic o_master_clear,
    input wire logic i_data_wire
);
    localparam int HALF_NS = 32;
    logic last_bit;
    logic drive;
    // A released line shows the inverse of the last bit, not a held value
    assign o_prog_data = drive ? last_bit : ~last_bit;
    initial begin
        o_prog_clock = 1'b0;
        o_master_clear = 1'b0;
        last_bit = 1'b0;
        drive = 1'b1;
    end
    // ****************************************
    // Link tasks
    // ****************************************
    // Data changes at the rise and holds over the fall; clock idles low
    task automatic send_bits(input logic [31:0] value, input int count);
        for (int i = count - 1; i >= 0; i--) begin
            o_prog_clock = 1'b1;
            drive = 1'b1;
            last_bit = value[i];
            #HALF_NS;
            o_prog_clock = 1'b0;
            #HALF_NS;
        end
    endtask
    task automatic enter(input logic [31:0] key);
        o_master_clear = 1'b1;
        #100;
        o_master_clear = 1'b0;
        #200;
        send_bits(key, 32);
        #100;
        o_master_clear = 1'b1;
        // Early edges that must be ignored while the port settles
        send_bits(32'h7, 3);
        #1100;
    endtask
    task automatic leave();
        #100;
        o_master_clear = 1'b0;
        #100;
    endtask
    task automatic exec_word(input logic [23:0] word);
        send_bits(32'h0, 4);
        send_bits({8'h00, word}, 24);
    endtask
    task automatic readout(output logic [15:0] value);
        send_bits(32'h1, 4);
        drive = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            o_prog_clock = 1'b1;
            #(HALF_NS - 1);
            value[i] = i_data_wire;
            #1;
            o_prog_clock = 1'b0;
            #HALF_NS;
        end
    endtask
endmodule

`default_nettype wire

// ==== verification/tb_serial_program_port.sv ====
// Testbench for the serial program port: entry, commands, FIFO and PC trip.
// Assumes the programmer model file is compiled before this one.
`timescale 1ns/100ps
`default_nettype none

module tb_serial_program_port;
    localparam logic [23:0] PC_TRIP = 24'h00020a;
    localparam logic [23:0] WORDS [4] = '{24'h000000, 24'hbb0bb6, 24'h040200, 24'ha8e761};
    logic i_sys_clk, i_rst, i_instr_ready, i_pc_load;
    logic [15:0] i_visi;
    logic [15:0] got;
    logic [23:0] i_pc_value, instr_data, pc;
    logic pgc, model_data, master_clear, data_wire, dut_data, dut_oe, prog_mode, io_hiz;
    logic suspend, cpu_exec, instr_valid, instr_lost, dev_reset;
    int fails = 0;
    int comparisons = 0;
    int resets_seen = 0;
    int popped = 0;
    assign data_wire = dut_oe ? dut_data : model_data;
    spp_prog_model i_prog (.o_prog_clock(pgc), .o_prog_data(model_data),
        .o_master_clear(master_clear), .i_data_wire(data_wire));
    spp_port #(.PC_LIMIT(PC_TRIP)) i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_prog_clock(pgc), .i_prog_data(data_wire), .o_prog_data(dut_data),
        .o_prog_data_oe(dut_oe), .i_master_clear(master_clear), .o_prog_mode(prog_mode),
        .o_io_hiz(io_hiz), .o_cpu_suspend(suspend), .o_cpu_exec(cpu_exec),
        .o_instr_data(instr_data), .o_instr_valid(instr_valid),
        .i_instr_ready(i_instr_ready), .o_instr_lost(instr_lost), .i_visi(i_visi),
        .i_pc_load(i_pc_load), .i_pc_value(i_pc_value), .o_pc(pc),
        .o_dev_reset(dev_reset));
    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        if (dev_reset === 1'b1) begin
            resets_seen++;
        end
        if (instr_valid === 1'b1 && i_instr_ready === 1'b1) begin
            popped++;
        end
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic run_wrong_key();
        i_prog.enter(spp_pkg::ENTRY_KEY ^ 32'h00000001);
        check("mode_bad_key", 24'(prog_mode), 24'h0);
        i_prog.leave();
    endtask
    task automatic run_entry();
        i_prog.enter(spp_pkg::ENTRY_KEY);
        check("mode_on", 24'(prog_mode), 24'h1);
        check("pins_hiz", 24'(io_hiz), 24'h1);
        i_prog.send_bits(32'h1f5, 9);
        cycles(8);
        check("forced_valid", 24'(instr_valid), 24'h1);
        check("forced_nop", instr_data, WORDS[0]);
        check("forced_exec", 24'(cpu_exec), 24'h1);
    endtask
    task automatic run_fill();
        @(posedge i_sys_clk);
        i_pc_load <= 1'b1;
        i_pc_value <= spp_pkg::PC_SAFE_BASE;
        @(posedge i_sys_clk);
        i_pc_load <= 1'b0;
        for (int k = 1; k < 4; k++) begin
            // The forced command is followed directly by the first word
            if (k > 1) i_prog.send_bits(32'h0, 4);
            cycles(8);
            check("suspend_on", 24'(suspend), 24'h1);
            i_prog.send_bits({8'h00, WORDS[k]}, 24);
            cycles(8);
            check("suspend_off", 24'(suspend), 24'h0);
            check("exec_on", 24'(cpu_exec), 24'h1);
        end
        check("pc_step", pc, 24'h000206);
        i_prog.exec_word(24'h883c22);
        cycles(8);
        check("word_lost", 24'(instr_lost), 24'h1);
    endtask
    task automatic run_readout(input logic [15:0] value);
        @(posedge i_sys_clk);
        i_visi <= value;
        i_prog.readout(got);
        check("visi_out", 24'(got), 24'(value));
        cycles(8);
        check("oe_released", 24'(dut_oe), 24'h0);
    endtask
    task automatic run_drain_trip();
        for (int k = 0; k < 4; k++) begin
            check("fifo_head", instr_data, WORDS[k]);
            @(posedge i_sys_clk);
            i_instr_ready <= 1'b1;
            @(posedge i_sys_clk);
            i_instr_ready <= 1'b0;
            cycles(1);
        end
        check("fifo_empty", 24'(instr_valid), 24'h0);
        check("pc_before_trip", pc, 24'h000208);
        i_prog.exec_word(WORDS[0]);
        cycles(8);
        check("reset_pulses", 24'(resets_seen), 24'h1);
        check("mode_after_trip", 24'(prog_mode), 24'h0);
        i_prog.leave();
    endtask
    task automatic run_exit();
        i_prog.enter(spp_pkg::ENTRY_KEY);
        i_prog.send_bits(32'h0, 9);
        check("mode_again", 24'(prog_mode), 24'h1);
        i_prog.leave();
        cycles(4);
        check("mode_off", 24'(prog_mode), 24'h0);
        check("hiz_off", 24'(io_hiz), 24'h0);
        check("lost_clear", 24'(instr_lost), 24'h0);
    endtask
    // One row of latch loads with periodic jumps back to the safe base
    task automatic run_program();
        int base;
        @(posedge i_sys_clk);
        i_instr_ready <= 1'b1;
        cycles(4);
        base = popped;
        i_prog.enter(spp_pkg::ENTRY_KEY);
        i_prog.send_bits(32'h0, 9);
        i_prog.send_bits({8'h00, WORDS[0]}, 24);
        i_prog.exec_word(24'h24003a);
        i_prog.exec_word(24'h883b0a);
        for (int g = 0; g < 16; g++) begin
            i_prog.exec_word(WORDS[2]);
            @(posedge i_sys_clk);
            i_pc_load <= 1'b1;
            i_pc_value <= spp_pkg::PC_SAFE_BASE;
            @(posedge i_sys_clk);
            i_pc_load <= 1'b0;
            i_prog.exec_word(WORDS[1]);
            i_prog.exec_word(WORDS[0]);
            i_prog.exec_word(WORDS[0]);
        end
        cycles(8);
        check("words_taken", 24'(popped - base), 24'd68);
        check("row_no_loss", 24'(instr_lost), 24'h0);
        check("pc_row_end", pc, 24'h000206);
        check("no_new_reset", 24'(resets_seen), 24'h1);
        i_prog.leave();
    endtask
    initial begin
        #400000;
        fails++;
        stop_test();
    end
    initial begin
        i_rst = 1'b1;
        i_instr_ready = 1'b0;
        i_pc_load = 1'b0;
        i_pc_value = 24'h000000;
        i_visi = 16'h0000;
        got = 16'h0000;
        repeat (10) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        cycles(4);
        run_wrong_key();
        run_entry();
        run_fill();
        run_readout(16'h8a5c);
        run_readout(16'h0000);
        run_drain_trip();
        run_exit();
        run_program();
        stop_test();
    end
endmodule

`default_nettype wire
